// ===== hw/rca_core.sv
// timekeeping, alarms and control register of the rtc core
`timescale 1ns/1ns
module rca_core import rca_pkg::*; #(
   parameter int OSC_HZ = OSC_HZ_DEF,
   parameter int BUSY_DELAY = BUSY_DELAY_CYCLES,
   parameter int TEMP_CONVERT_REQUEST_LEN = TEMP_CONVERT_REQUEST_CYCLES
) (
   input wire logic clock, // 100 MHz core clock
   input wire logic srst, // synchronous reset, high
   input wire logic ce, // clock enable, freezes all state
   input wire logic oscClk, // oscillator square wave, asynchronous
   input wire logic mainPowerLow, // main supply below trip, asynchronous
   input wire logic busStart, // bus START seen, pulse
   input wire logic ptrWrap, // register pointer wrapped to zero, pulse
   input wire logic [ADDR_W-1:0] regAddr, // register address
   input wire logic [7:0] regWrData, // write data
   input wire logic regWrite, // write strobe at data acknowledge
   input wire logic regRead, // read strobe
   output logic [7:0] regRdData, // read data
   output logic regRdValid, // read data valid, pulse
   output logic irqWaveOut, // pin level when driven, always low
   output logic irqWaveOe, // pin pulled low while high
   output logic compensationBusy // conversion in progress
);
   localparam int CHAIN_W = $clog2(OSC_HZ);

   logic oscS1, oscS2, oscS3, batS1, batS2;
   logic [CHAIN_W-1:0] chain;
   logic secTick, alarmCheck;
   logic [7:0] tSec, tMin, tHour, tDay, tDate, tMonth, tYear;
   logic [7:0] almReg [ALM_REGS];
   logic oscStopOnBattery, batteryOutputKeep, tempConvertRequest;
   logic waveRateSelHi, waveRateSelLo, irqOrWaveSelect;
   logic alarmOneIrqEnable, alarmTwoIrqEnable, alarmOneFlag, alarmTwoFlag;
   rca_temp_convert_request_t convState;
   logic [31:0] convTimer;
   logic [5:0] autoCnt;
   logic rdFromMem, rdPend;
   logic [7:0] rdOther, memRd;
   logic oscEdge, oscRunning, secWrite, statWrite, convStart;
   logic [7:0] next_hour, daysMax, hourInc, monthInc;
   logic midnight, monthEnd, yearWrap, leapYear, alarmOneHit, alarmTwoHit;
   logic irqActive, wave, pinGate;

   // --------------------------------------------------------------
   // input crossing and oscillator edge
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         {oscS1, oscS2, oscS3, batS1, batS2} <= 5'h00;
      end else if (ce) begin
         oscS1 <= oscClk;
         oscS2 <= oscS1;
         oscS3 <= oscS2;
         batS1 <= mainPowerLow;
         batS2 <= batS1;
      end
   end

   assign oscEdge = oscS2 & ~oscS3;
   assign oscRunning = ~(oscStopOnBattery & batS2);
   assign secWrite = regWrite && regAddr == ADDR_SEC;
   assign statWrite = regWrite && regAddr == ADDR_STAT;

   // --------------------------------------------------------------
   // sub-second up-counting chain
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         chain <= '0;
         secTick <= 1'b0;
         alarmCheck <= 1'b0;
      end else if (ce) begin
         secTick <= 1'b0;
         alarmCheck <= secTick;
         if (secWrite) begin
            chain <= '0;
         end else if (oscEdge && oscRunning) begin
            if (chain == CHAIN_W'(OSC_HZ - 1)) begin
               chain <= '0;
               secTick <= 1'b1;
            end else begin
               chain <= chain + 1'b1;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // calendar arithmetic
   // --------------------------------------------------------------
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   // tens digit weighs 2 modulo 4, so bit 4 folds into the low pair
   assign leapYear = (tYear[1:0] + {tYear[4], 1'b0}) == 2'b00;
   assign midnight = tHour[HOUR_12_BIT] ? (tHour[HOUR_PM_BIT] && tHour[4:0] == 5'h11)
                                        : tHour[5:0] == 6'h23;
   assign monthEnd = tDate == daysMax;
   assign yearWrap = secTick && tSec == 8'h59 && tMin == 8'h59 && midnight && monthEnd
                     && tMonth[4:0] == 5'h12 && tYear == 8'h99;
   // carries stay in the digit pairs, so the pm flag rides along in 12 hour mode
   assign hourInc = bcdInc({2'h0, tHour[5:0]});
   assign monthInc = bcdInc({3'h0, tMonth[4:0]});

   always_comb begin
      unique case (tMonth[4:0])
         5'h02: daysMax = leapYear ? 8'h29 : 8'h28;
         5'h04, 5'h06, 5'h09, 5'h11: daysMax = 8'h30;
         default: daysMax = 8'h31;
      endcase
   end

   always_comb begin
      next_hour = tHour;
      if (tHour[HOUR_12_BIT]) begin
         if (tHour[4:0] == 5'h12) begin
            next_hour[4:0] = 5'h01;
         end else if (tHour[4:0] == 5'h11) begin
            next_hour[4:0] = 5'h12;
            next_hour[HOUR_PM_BIT] = ~tHour[HOUR_PM_BIT];
         end else begin
            next_hour[4:0] = hourInc[4:0];
         end
      end else begin
         next_hour[5:0] = midnight ? 6'h00 : hourInc[5:0];
      end
   end

   // --------------------------------------------------------------
   // time registers: second update first, host writes override
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         {tSec, tMin, tHour, tYear} <= {4{TIME_RESET}};
         {tDay, tDate, tMonth} <= {3{ONE_RESET}};
      end else if (ce) begin
         if (secTick) begin
            tSec <= (tSec == 8'h59) ? 8'h00 : bcdInc(tSec);
            if (tSec == 8'h59) begin
               tMin <= (tMin == 8'h59) ? 8'h00 : bcdInc(tMin);
               if (tMin == 8'h59) begin
                  tHour <= next_hour;
                  if (midnight) begin
                     tDay <= (tDay == 8'h07) ? 8'h01 : bcdInc(tDay);
                     tDate <= monthEnd ? 8'h01 : bcdInc(tDate);
                     if (monthEnd) begin
                        if (tMonth[4:0] == 5'h12) begin
                           tMonth <= {~tMonth[CENTURY_BIT], 7'h01};
                           tYear <= (tYear == 8'h99) ? 8'h00 : bcdInc(tYear);
                        end else begin
                           tMonth <= {tMonth[7:5], monthInc[4:0]};
                        end
                     end
                  end
               end
            end
         end
         if (regWrite) begin
            unique case (regAddr)
               ADDR_SEC: tSec <= regWrData & SEC_MASK;
               ADDR_MIN: tMin <= regWrData & MIN_MASK;
               ADDR_HOUR: tHour <= regWrData & HOUR_MASK;
               ADDR_DAY: tDay <= regWrData & DAY_MASK;
               ADDR_DATE: tDate <= regWrData & DATE_MASK;
               ADDR_MONTH: tMonth <= regWrData & MONTH_MASK;
               ADDR_YEAR: tYear <= regWrData;
               default: ;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // alarm registers and match
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < ALM_REGS; i++) begin
            almReg[i] <= TIME_RESET;
         end
      end else if (ce && regWrite && regAddr >= ADDR_ALM_FIRST && regAddr <= ADDR_ALM_LAST) begin
         almReg[3'(regAddr - ADDR_ALM_FIRST)] <= regWrData;
      end
   end

   function automatic logic dayHit(input logic [7:0] a, input logic [7:0] d, input logic [7:0] w);
      dayHit = a[DAY_SEL_BIT] ? (a[3:0] == w[3:0]) : (a[5:0] == d[5:0]);
   endfunction

   // a set mask bit frees its field, so the patterns fall out of one and-chain
   assign alarmOneHit = (almReg[0][ALM_MASK_BIT] || almReg[0][6:0] == tSec[6:0])
                     && (almReg[1][ALM_MASK_BIT] || almReg[1][6:0] == tMin[6:0])
                     && (almReg[2][ALM_MASK_BIT] || almReg[2][6:0] == tHour[6:0])
                     && (almReg[3][ALM_MASK_BIT] || dayHit(almReg[3], tDate, tDay));
   assign alarmTwoHit = tSec == 8'h00
                     && (almReg[4][ALM_MASK_BIT] || almReg[4][6:0] == tMin[6:0])
                     && (almReg[5][ALM_MASK_BIT] || almReg[5][6:0] == tHour[6:0])
                     && (almReg[6][ALM_MASK_BIT] || dayHit(almReg[6], tDate, tDay));

   always_ff @(posedge clock) begin
      if (srst) begin
         alarmOneFlag <= 1'b0;
         alarmTwoFlag <= 1'b0;
      end else if (ce) begin
         // a match in the clearing cycle still sets the flag
         alarmOneFlag <= (alarmCheck && alarmOneHit)
                      || (alarmOneFlag && !(statWrite && !regWrData[STAT_A1F]));
         alarmTwoFlag <= (alarmCheck && alarmTwoHit)
                      || (alarmTwoFlag && !(statWrite && !regWrData[STAT_A2F]));
      end
   end

   // --------------------------------------------------------------
   // control register
   // --------------------------------------------------------------
   assign convStart = regWrite && regAddr == ADDR_CTRL && regWrData[CTRL_TEMP_CONVERT_REQUEST]
                      && convState == TEMP_CONVERT_REQUEST_IDLE && !tempConvertRequest;

   always_ff @(posedge clock) begin
      if (srst) begin
         {oscStopOnBattery, batteryOutputKeep} <= CTRL_RESET[7:6];
         {waveRateSelHi, waveRateSelLo, irqOrWaveSelect} <= CTRL_RESET[4:2];
         {alarmTwoIrqEnable, alarmOneIrqEnable} <= CTRL_RESET[1:0];
      end else if (ce && regWrite && regAddr == ADDR_CTRL) begin
         oscStopOnBattery <= regWrData[CTRL_OSC_STOP];
         batteryOutputKeep <= regWrData[CTRL_KEEP];
         waveRateSelHi <= regWrData[CTRL_RATE_HI];
         waveRateSelLo <= regWrData[CTRL_RATE_LO];
         irqOrWaveSelect <= regWrData[CTRL_INT_SEL];
         alarmTwoIrqEnable <= regWrData[CTRL_ALARM_TWO_IRQ_ENABLE];
         alarmOneIrqEnable <= regWrData[CTRL_ALARM_ONE_IRQ_ENABLE];
      end
   end

   // --------------------------------------------------------------
   // temperature conversion sequencer
   // --------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         convState <= TEMP_CONVERT_REQUEST_IDLE;
         convTimer <= '0;
         autoCnt <= '0;
         tempConvertRequest <= 1'b0;
         compensationBusy <= 1'b0;
      end else if (ce) begin
         if (secTick) begin
            autoCnt <= autoCnt + 6'h01;
         end
         unique case (convState)
            TEMP_CONVERT_REQUEST_IDLE: begin
               if (convStart) begin
                  tempConvertRequest <= 1'b1;
                  convTimer <= 32'(BUSY_DELAY - 1);
                  convState <= TEMP_CONVERT_REQUEST_WAIT;
               end else if (secTick && autoCnt == AUTO_TEMP_CONVERT_REQUEST_LAST) begin
                  compensationBusy <= 1'b1;
                  convTimer <= 32'(TEMP_CONVERT_REQUEST_LEN - 1);
                  convState <= TEMP_CONVERT_REQUEST_BUSY;
               end
            end
            TEMP_CONVERT_REQUEST_WAIT: begin
               if (convTimer == 32'h0) begin
                  compensationBusy <= 1'b1;
                  convTimer <= 32'(TEMP_CONVERT_REQUEST_LEN - 1);
                  convState <= TEMP_CONVERT_REQUEST_BUSY;
               end else begin
                  convTimer <= convTimer - 32'h1;
               end
            end
            TEMP_CONVERT_REQUEST_BUSY: begin
               if (convTimer == 32'h0) begin
                  compensationBusy <= 1'b0;
                  tempConvertRequest <= 1'b0;
                  convState <= TEMP_CONVERT_REQUEST_IDLE;
               end else begin
                  convTimer <= convTimer - 32'h1;
               end
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // shared output pin
   // --------------------------------------------------------------
   assign irqActive = (alarmOneFlag && alarmOneIrqEnable) || (alarmTwoFlag && alarmTwoIrqEnable);
   assign pinGate = !batS2 || batteryOutputKeep;

   always_comb begin
      unique case ({waveRateSelHi, waveRateSelLo})
         2'b00: wave = chain >= CHAIN_W'(OSC_HZ / 2);
         2'b01: wave = chain[4];
         2'b10: wave = chain[2];
         2'b11: wave = chain[1];
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         irqWaveOut <= 1'b0;
         irqWaveOe <= 1'b0;
      end else if (ce) begin
         irqWaveOut <= 1'b0;
         irqWaveOe <= pinGate && (irqOrWaveSelect ? irqActive : !wave);
      end
   end

   // --------------------------------------------------------------
   // read path: snapshot for time, live for the rest
   // --------------------------------------------------------------
   rca_snap_mem #(.WIDTH(8), .DEPTH(TIME_REGS)) uSnap (
      .clock(clock),
      .ce(ce),
      .snapEn(busStart || ptrWrap),
      .snapData({tYear, tMonth, tDay == 8'h00 ? 8'h00 : tDay, tDate, tHour, tMin, tSec}),
      .rdAddr(regAddr[2:0]),
      .rdData(memRd)
   );

   always_ff @(posedge clock) begin
      if (srst) begin
         rdFromMem <= 1'b0;
         rdPend <= 1'b0;
         rdOther <= 8'h00;
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else if (ce) begin
         rdPend <= regRead;
         rdFromMem <= regAddr <= ADDR_YEAR;
         if (regAddr >= ADDR_ALM_FIRST && regAddr <= ADDR_ALM_LAST) begin
            rdOther <= almReg[3'(regAddr - ADDR_ALM_FIRST)];
         end else if (regAddr == ADDR_CTRL) begin
            rdOther <= {oscStopOnBattery, batteryOutputKeep, tempConvertRequest, waveRateSelHi,
                        waveRateSelLo, irqOrWaveSelect, alarmTwoIrqEnable, alarmOneIrqEnable};
         end else if (regAddr == ADDR_STAT) begin
            rdOther <= {5'h00, compensationBusy, alarmTwoFlag, alarmOneFlag};
         end else begin
            rdOther <= 8'h00;
         end
         regRdValid <= rdPend;
         // result held until the next read; a time read before the first snapshot returns unknown
         if (rdPend) begin
            regRdData <= rdFromMem ? memRd : rdOther;
         end
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   secBcd_a:
      assert property (@(posedge clock) disable iff (srst) tSec[3:0] <= 4'h9)
      else $error("seconds digit left BCD range");
   hour24_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         secTick && !tHour[HOUR_12_BIT] && tHour[5:0] == 6'h23 && tMin == 8'h59 && tSec == 8'h59
         |=> tHour[5:0] == 6'h00 && !tHour[HOUR_12_BIT])
      else $error("24 hour wrap wrong");
   century_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         yearWrap && !regWrite |=> tMonth[CENTURY_BIT] != $past(tMonth[CENTURY_BIT]) && tYear == 8'h00)
      else $error("century did not toggle");
   chainReset_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         secWrite |=> !secTick ##0 chain == '0 ##1 !secTick)
      else $error("seconds write did not reset chain");
   flagSet_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         alarmCheck && alarmOneHit |=> alarmOneFlag)
      else $error("alarm one flag not set");
   flagTick_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         $rose(alarmTwoFlag) |-> $past(alarmCheck))
      else $error("alarm two flag set outside update");
   flagKeep_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         alarmOneFlag && !(statWrite && !regWrData[STAT_A1F]) |=> alarmOneFlag)
      else $error("alarm one flag lost without zero write");
   busyLate_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         convStart |=> tempConvertRequest && !compensationBusy)
      else $error("conversion request or busy wrong after start");
   pinIrq_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         irqOrWaveSelect && irqActive && pinGate |=> irqWaveOe && !irqWaveOut)
      else $error("interrupt not driven");
   pinOff_a:
      assert property (@(posedge clock) disable iff (srst || !ce)
         !pinGate |=> !irqWaveOe)
      else $error("pin driven on battery without keep");

   alarmFire_c: cover property (@(posedge clock) disable iff (srst) $rose(alarmOneFlag));
   centuryWrap_c: cover property (@(posedge clock) disable iff (srst) yearWrap);
   convDone_c: cover property (@(posedge clock) disable iff (srst) $fell(tempConvertRequest));
   pinLow_c: cover property (@(posedge clock) disable iff (srst) irqOrWaveSelect && irqWaveOe);
endmodule

// ===== hw/rca_pkg.sv
// shared constants of the rtc calendar, alarm and control core
package rca_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_HZ_DEF = 32768;
   localparam int BUSY_DELAY_MS = 2;
   localparam int BUSY_DELAY_CYCLES = BUSY_DELAY_MS * (CLK_HZ / 1000);
   localparam int TEMP_CONVERT_REQUEST_TIME_MS = 10;
   localparam int TEMP_CONVERT_REQUEST_CYCLES = TEMP_CONVERT_REQUEST_TIME_MS * (CLK_HZ / 1000);
   localparam logic [5:0] AUTO_TEMP_CONVERT_REQUEST_LAST = 6'h3f;
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_SEC = 5'h00;
   localparam logic [4:0] ADDR_MIN = 5'h01;
   localparam logic [4:0] ADDR_HOUR = 5'h02;
   localparam logic [4:0] ADDR_DAY = 5'h03;
   localparam logic [4:0] ADDR_DATE = 5'h04;
   localparam logic [4:0] ADDR_MONTH = 5'h05;
   localparam logic [4:0] ADDR_YEAR = 5'h06;
   localparam logic [4:0] ADDR_ALM_FIRST = 5'h07;
   localparam logic [4:0] ADDR_ALM_LAST = 5'h0d;
   localparam logic [4:0] ADDR_CTRL = 5'h0e;
   localparam logic [4:0] ADDR_STAT = 5'h0f;
   localparam int ALM_REGS = 7;
   localparam int TIME_REGS = 7;
   localparam logic [7:0] CTRL_RESET = 8'h1c;
   localparam int CTRL_OSC_STOP = 7;
   localparam int CTRL_KEEP = 6;
   localparam int CTRL_TEMP_CONVERT_REQUEST = 5;
   localparam int CTRL_RATE_HI = 4;
   localparam int CTRL_RATE_LO = 3;
   localparam int CTRL_INT_SEL = 2;
   localparam int CTRL_ALARM_TWO_IRQ_ENABLE = 1;
   localparam int CTRL_ALARM_ONE_IRQ_ENABLE = 0;
   localparam int STAT_BUSY = 2;
   localparam int STAT_A2F = 1;
   localparam int STAT_A1F = 0;
   localparam int ALM_MASK_BIT = 7;
   localparam int HOUR_12_BIT = 6;
   localparam int HOUR_PM_BIT = 5;
   localparam int DAY_SEL_BIT = 6;
   localparam int CENTURY_BIT = 7;
   localparam logic [7:0] SEC_MASK = 8'h7f;
   localparam logic [7:0] MIN_MASK = 8'h7f;
   localparam logic [7:0] HOUR_MASK = 8'h7f;
   localparam logic [7:0] DAY_MASK = 8'h07;
   localparam logic [7:0] DATE_MASK = 8'h3f;
   localparam logic [7:0] MONTH_MASK = 8'h9f;
   localparam logic [7:0] TIME_RESET = 8'h00;
   localparam logic [7:0] ONE_RESET = 8'h01;
   typedef enum logic [1:0] {TEMP_CONVERT_REQUEST_IDLE, TEMP_CONVERT_REQUEST_WAIT, TEMP_CONVERT_REQUEST_BUSY} rca_temp_convert_request_t;
endpackage

// ===== hw/rca_snap_mem.sv
// snapshot buffer of the time registers with registered read data
`timescale 1ns/1ns
module rca_snap_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 7
) (
   input wire logic clock, // core clock
   input wire logic ce, // clock enable
   input wire logic snapEn, // copy all entries at once
   input wire logic [WIDTH*DEPTH-1:0] snapData, // entry i at bits i*WIDTH
   input wire logic [$clog2(DEPTH)-1:0] rdAddr, // read index
   output logic [WIDTH-1:0] rdData // read data, one cycle late
);
   logic [WIDTH-1:0] mem [DEPTH];

   // --------------------------------------------------------------
   // entries
   // --------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : gEntry
      always_ff @(posedge clock) begin
         if (ce && snapEn) begin
            mem[i] <= snapData[i*WIDTH +: WIDTH];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (ce) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// ===== tb/rca_host_model.sv
// host model that drives the register port of the rtc core
`timescale 1ns/1ns
module rca_host_model (
   input wire logic clock, // core clock
   output logic busStart, // start pulse
   output logic ptrWrap, // pointer wrap pulse
   output logic [4:0] regAddr, // register address
   output logic [7:0] regWrData, // write data
   output logic regWrite, // write strobe
   output logic regRead, // read strobe
   input wire logic [7:0] regRdData, // read data
   input wire logic regRdValid // read data valid
);
   // ----------------------------------------
   // register access
   // ----------------------------------------
   initial begin
      {busStart, ptrWrap, regWrite, regRead, regAddr, regWrData} = '0;
   end
   // one cycle gap between strobes keeps each access a clean single pulse
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clock);
      regWrite = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      int i;
      @(negedge clock);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clock);
      regRead = 1'b0;
      for (i = 0; i < 4 && regRdValid !== 1'b1; i++) @(posedge clock) #1;
      // a missing answer comes back unknown, so the compare cannot pass on stale data
      d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
   endtask
   task automatic snap(input logic wrap);
      @(negedge clock);
      busStart = !wrap;
      ptrWrap = wrap;
      @(negedge clock);
      {busStart, ptrWrap} = 2'b00;
   endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench of the rtc calendar, alarm and control core
`timescale 1ns/1ns
module testbench;
   logic clock = 1'b0, srst = 1'b1, oscClk, mainPowerLow, ce;
   logic busStart, ptrWrap, regWrite, regRead, regRdValid, irqWaveOut, irqWaveOe, compensationBusy;
   logic [4:0] regAddr;
   logic [7:0] regWrData, regRdData, v;
   int num_errors = 0, n_compared = 0, cycles = 0;
   rca_core #(.OSC_HZ(64), .BUSY_DELAY(5), .TEMP_CONVERT_REQUEST_LEN(10)) u_dut (.clock(clock), .srst(srst),
      .ce(ce), .oscClk(oscClk), .mainPowerLow(mainPowerLow), .busStart(busStart),
      .ptrWrap(ptrWrap), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
      .irqWaveOut(irqWaveOut), .irqWaveOe(irqWaveOe), .compensationBusy(compensationBusy));
   rca_host_model u_host (.clock(clock), .busStart(busStart), .ptrWrap(ptrWrap),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .regRdValid(regRdValid));
   initial forever #5 clock = !clock;
   // oscillator runs free, phase unrelated to the core clock
   initial begin
      oscClk = 1'b0;
      #3;
      forever #80 oscClk = !oscClk;
   end
   // about six simulated seconds are needed; the ceiling leaves margin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end
   // ----------------------------------------
   // checks and scenarios
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic roll();
      logic [7:0] s[7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
      logic [7:0] e[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00};
      int i;
      rc(5'h0e, 8'h1c);
      rc(5'h0f, 8'h00);
      rc(5'h10, 8'h00);
      chk({7'h0, irqWaveOe}, 8'h00);
      u_host.wr(5'h0e, 8'h06);
      for (i = 11; i < 14; i++) u_host.wr(i[4:0], 8'h80);
      for (i = 0; i < 7; i++) u_host.wr(i[4:0], s[i]);
      repeat (1100) @(negedge clock);
      u_host.snap(1'b0);
      for (i = 0; i < 7; i++) rc(i[4:0], e[i]);
      rc(5'h0f, 8'h02);
      chk({7'h0, irqWaveOe}, 8'h01);
      $display("rollover test done");
   endtask
   task automatic flags();
      int i;
      u_host.wr(5'h0f, 8'h03);
      rc(5'h0f, 8'h02);
      u_host.wr(5'h0f, 8'h01);
      rc(5'h0f, 8'h00);
      chk({7'h0, irqWaveOe}, 8'h00);
      for (i = 7; i < 11; i++) u_host.wr(i[4:0], 8'h80);
      u_host.wr(5'h0e, 8'h05);
      repeat (1100) @(negedge clock);
      rc(5'h0f, 8'h01);
      chk({7'h0, irqWaveOe}, 8'h01);
      chk({7'h0, irqWaveOut}, 8'h00);
      u_host.wr(5'h0e, 8'h04);
      repeat (2) @(negedge clock);
      chk({7'h0, irqWaveOe}, 8'h00);
      $display("alarm flag test done");
   endtask
   task automatic stop();
      u_host.wr(5'h0e, 8'h85);
      mainPowerLow = 1'b1;
      repeat (6) @(negedge clock);
      chk({7'h0, irqWaveOe}, 8'h00);
      u_host.snap(1'b0);
      u_host.rd(5'h00, v);
      repeat (1100) @(negedge clock);
      u_host.snap(1'b0);
      rc(5'h00, v);
      u_host.wr(5'h0e, 8'hc5);
      repeat (2) @(negedge clock);
      chk({7'h0, irqWaveOe}, 8'h01);
      mainPowerLow = 1'b0;
      $display("oscillator stop test done");
   endtask
   task automatic hour12();
      u_host.wr(5'h0e, 8'h04);
      u_host.wr(5'h00, 8'h59);
      u_host.wr(5'h01, 8'h59);
      u_host.wr(5'h02, 8'h71);
      repeat (1100) @(negedge clock);
      u_host.snap(1'b1);
      rc(5'h02, 8'h52);
      $display("twelve hour test done");
   endtask
   task automatic temp_convert_request();
      u_host.wr(5'h0e, 8'h24);
      chk({7'h0, compensationBusy}, 8'h00);
      rc(5'h0e, 8'h24);
      repeat (6) @(negedge clock);
      chk({7'h0, compensationBusy}, 8'h01);
      repeat (15) @(negedge clock);
      rc(5'h0e, 8'h04);
      chk({7'h0, compensationBusy}, 8'h00);
      $display("conversion test done");
   endtask
   // a square wave of half period n cycles flips exactly once in any n-cycle window
   task automatic rate(input logic [7:0] c, input int n);
      logic [7:0] w;
      u_host.wr(5'h0e, c);
      repeat (4) @(negedge clock);
      w = {7'h0, irqWaveOe};
      repeat (n) @(negedge clock);
      chk({7'h0, irqWaveOe}, ~w & 8'h01);
   endtask
   task automatic wave();
      u_host.wr(5'h0e, 8'h00);
      u_host.wr(5'h00, 8'h00);
      repeat (300) @(negedge clock);
      chk({7'h0, irqWaveOe}, 8'h01);
      ce = 1'b0;
      repeat (400) @(negedge clock);
      chk({7'h0, irqWaveOe}, 8'h01);
      ce = 1'b1;
      repeat (400) @(negedge clock);
      chk({7'h0, irqWaveOe}, 8'h00);
      rate(8'h18, 32);
      rate(8'h10, 64);
      rate(8'h08, 256);
      $display("square wave test done");
   endtask
   task automatic results();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      {mainPowerLow, ce} = 2'b01;
      repeat (10) @(negedge clock);
      srst = 1'b0;
      roll();
      flags();
      stop();
      hour12();
      temp_convert_request();
      wave();
      results();
   end
endmodule
